// *** src/cmx_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmx_exec
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // instruction in
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [1:0]  bank_sel,
  // instruction status
  output var  logic        busy,
  output var  logic        done,
  output var  logic [15:0] program_counter,
  // core registers and flags
  output var  logic [7:0]  accumulator,
  output var  logic [7:0]  aux_reg,
  output var  logic [7:0]  stack_pointer,
  output var  logic        carry_flag,
  output var  logic        overflow_flag,
  output var  logic        parity_flag,
  // interrupt controller
  output var  logic        int_level_release,
  output var  logic        int_hold,
  // internal data ram and direct space
  output var  logic [7:0]  mem_addr,
  output var  logic [7:0]  mem_wdata,
  output var  logic        mem_we,
  output var  logic        mem_re,
  output var  logic        mem_latch_rd,
  input  wire logic [7:0]  mem_rdata
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    cmx_phase_t  ph;
    logic [7:0]  op;
    logic [7:0]  opnd1;
    logic [7:0]  opnd2;
    logic [3:0]  cnt;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  aux;
    logic [7:0]  sp;
    logic        cy;
    logic        ov;
    logic        par;
    logic        busy;
    logic        done;
    logic        rel;
    logic        hold;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
    logic        latch;
  } cmx_state_t;

  cmx_state_t s_r;
  cmx_state_t s_nxt;

  function automatic logic [7:0] rd_int(input logic [7:0] dir,
                                        input cmx_state_t st);
    if (dir == SP_ADDR)
      return st.sp;
    else if (dir == ACC_ADDR)
      return st.acc;
    else
      return st.aux;
  endfunction

  // ****************************************************
  // sequencer
  // ****************************************************
  always_comb begin
    logic [15:0] prod;
    logic [7:0]  val;
    logic [7:0]  mask;
    logic        bitv;
    prod  = 16'h0000;
    val   = 8'h00;
    mask  = 8'h00;
    bitv  = 1'b0;
    s_nxt = s_r;
    s_nxt.done  = 1'b0;
    s_nxt.rel   = 1'b0;
    s_nxt.we    = 1'b0;
    s_nxt.re    = 1'b0;
    s_nxt.latch = 1'b0;
    if (s_r.cnt != 4'h0)
      s_nxt.cnt = s_r.cnt - 4'h1;
    mask = (s_r.op == OP_OR_D_A) ? s_r.acc : s_r.opnd2;
    case (s_r.ph)
      ST_IDLE: begin
        if (instr_valid) begin
          s_nxt.op    = opcode;
          s_nxt.opnd1 = operand1;
          s_nxt.opnd2 = operand2;
          s_nxt.busy  = 1'b1;
          s_nxt.cnt   = mcycles_of(opcode) * CLKS_PER_MCYCLE - 4'h1;
          s_nxt.ph    = ST_FINISH;
          mask = (opcode == OP_OR_D_A) ? s_r.acc : operand2;
          case (opcode)
            OP_NOP: begin
              s_nxt.ph = ST_FINISH;
            end
            OP_RL: begin
              s_nxt.acc = {s_r.acc[6:0], s_r.acc[7]};
            end
            OP_RLC: begin
              s_nxt.acc = {s_r.acc[6:0], s_r.cy};
              s_nxt.cy  = s_r.acc[7];
            end
            OP_MUL: begin
              prod      = s_r.acc * s_r.aux;
              s_nxt.acc = prod[7:0];
              s_nxt.aux = prod[15:8];
              s_nxt.ov  = prod[15:8] != 8'h00;
              s_nxt.cy  = 1'b0;
            end
            OP_OR_A_IMM: begin
              s_nxt.acc = s_r.acc | operand1;
            end
            OP_OR_A_DIR: begin
              if (is_internal(operand1))
                s_nxt.acc = s_r.acc | rd_int(operand1, s_r);
              else begin
                s_nxt.addr = operand1;
                s_nxt.re   = 1'b1;
                s_nxt.ph   = ST_RD;
              end
            end
            OP_OR_D_A, OP_OR_D_IMM: begin
              if (operand1 == ACC_ADDR)
                s_nxt.acc = s_r.acc | mask;
              else if (operand1 == AUX_ADDR)
                s_nxt.aux = s_r.aux | mask;
              else if (operand1 == SP_ADDR)
                s_nxt.sp = s_r.sp | mask;
              else begin
                s_nxt.addr  = operand1;
                s_nxt.re    = 1'b1;
                s_nxt.latch = 1'b1;
                s_nxt.ph    = ST_RD;
              end
            end
            OP_OR_C_BIT, OP_OR_C_NBT: begin
              val = bit_byte(operand1);
              if (is_internal(val)) begin
                bitv = 1'((rd_int(val, s_r) >> operand1[2:0]) & 8'h01);
                if (bitv ^ (opcode == OP_OR_C_NBT))
                  s_nxt.cy = 1'b1;
              end else begin
                s_nxt.addr = val;
                s_nxt.re   = 1'b1;
                s_nxt.ph   = ST_RD;
              end
            end
            OP_PUSH: begin
              s_nxt.sp = s_r.sp + 8'h01;
              if (is_internal(operand1)) begin
                s_nxt.addr  = s_r.sp + 8'h01;
                s_nxt.wdata = rd_int(operand1, s_r);
                s_nxt.we    = 1'b1;
              end else begin
                s_nxt.addr = operand1;
                s_nxt.re   = 1'b1;
                s_nxt.ph   = ST_RD;
              end
            end
            OP_POP, OP_RET, OP_INTERRUPT_RETURN_OP: begin
              s_nxt.addr = s_r.sp;
              s_nxt.re   = 1'b1;
              s_nxt.ph   = ST_RD;
            end
            default: begin
              if (opcode[7:3] == OP_OR_A_RN ||
                  opcode[7:1] == OP_OR_A_IND) begin
                // indirect form only has R0/R1, low opcode bit picks one
                s_nxt.addr = opcode[3] ? {3'h0, bank_sel, opcode[2:0]}
                                       : {3'h0, bank_sel, 2'h0, opcode[0]};
                s_nxt.re   = 1'b1;
                s_nxt.ph   = opcode[3] ? ST_RD : ST_PTR;
              end
            end
          endcase
        end
      end
      ST_PTR: begin
        s_nxt.addr = mem_rdata;
        s_nxt.re   = 1'b1;
        s_nxt.ph   = ST_RD;
      end
      ST_RD: begin
        s_nxt.ph = ST_FINISH;
        case (s_r.op)
          OP_OR_D_A, OP_OR_D_IMM: begin
            s_nxt.wdata = mem_rdata | mask;
            s_nxt.we    = 1'b1;
          end
          OP_OR_C_BIT, OP_OR_C_NBT: begin
            bitv = mem_rdata[s_r.opnd1[2:0]];
            if (bitv ^ (s_r.op == OP_OR_C_NBT))
              s_nxt.cy = 1'b1;
          end
          OP_PUSH: begin
            s_nxt.addr  = s_r.sp;
            s_nxt.wdata = mem_rdata;
            s_nxt.we    = 1'b1;
          end
          OP_POP: begin
            s_nxt.sp = s_r.sp - 8'h01;
            if (s_r.opnd1 == SP_ADDR)
              s_nxt.sp = mem_rdata;
            else if (s_r.opnd1 == ACC_ADDR)
              s_nxt.acc = mem_rdata;
            else if (s_r.opnd1 == AUX_ADDR)
              s_nxt.aux = mem_rdata;
            else begin
              s_nxt.addr  = s_r.opnd1;
              s_nxt.wdata = mem_rdata;
              s_nxt.we    = 1'b1;
            end
          end
          OP_RET, OP_INTERRUPT_RETURN_OP: begin
            s_nxt.pc[15:8] = mem_rdata;
            s_nxt.sp       = s_r.sp - 8'h01;
            s_nxt.addr     = s_r.sp - 8'h01;
            s_nxt.re       = 1'b1;
            s_nxt.ph       = ST_RD_LO;
          end
          default: begin
            s_nxt.acc = s_r.acc | mem_rdata;
          end
        endcase
      end
      ST_RD_LO: begin
        s_nxt.pc[7:0] = mem_rdata;
        s_nxt.sp      = s_r.sp - 8'h01;
        s_nxt.ph      = ST_FINISH;
      end
      ST_FINISH: begin
        // fetch cycles share the slot count; they stretch the slot only when they outlast it, never shorten it
        if (s_r.cnt == 4'h0) begin
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.ph   = ST_IDLE;
          if (s_r.op != OP_RET && s_r.op != OP_INTERRUPT_RETURN_OP)
            s_nxt.pc = s_r.pc + {14'h0000, bytes_of(s_r.op)};
          if (s_r.op == OP_INTERRUPT_RETURN_OP) begin
            s_nxt.rel  = 1'b1;
            s_nxt.hold = 1'b1;
          end else
            s_nxt.hold = 1'b0;
        end
      end
      default: begin
        s_nxt.ph = ST_IDLE;
      end
    endcase
    s_nxt.par = ^s_nxt.acc;
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r       <= '0;
      s_r.ph    <= ST_IDLE;
      s_r.pc    <= PC_RST;
      s_r.acc   <= ACC_RST;
      s_r.aux   <= AUX_RST;
      s_r.sp    <= SP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign busy              = s_r.busy;
  assign done              = s_r.done;
  assign program_counter   = s_r.pc;
  assign accumulator       = s_r.acc;
  assign aux_reg           = s_r.aux;
  assign stack_pointer     = s_r.sp;
  assign carry_flag        = s_r.cy;
  assign overflow_flag     = s_r.ov;
  assign parity_flag       = s_r.par;
  assign int_level_release = s_r.rel;
  assign int_hold          = s_r.hold;
  assign mem_addr          = s_r.addr;
  assign mem_wdata         = s_r.wdata;
  assign mem_we            = s_r.we;
  assign mem_re            = s_r.re;
  assign mem_latch_rd      = s_r.latch;

endmodule
`default_nettype wire

// *** src/cmx_pkg.sv ***
`default_nettype none
package cmx_pkg;

  // ****************************************************
  // machine cycle and reset values
  // ****************************************************
  localparam logic [3:0]  CLKS_PER_MCYCLE = 4'h2;
  localparam logic [7:0]  ACC_RST         = 8'h00;
  localparam logic [7:0]  AUX_RST         = 8'h00;
  localparam logic [7:0]  SP_RST          = 8'h07;
  localparam logic [15:0] PC_RST          = 16'h0000;

  // ****************************************************
  // direct addresses held inside this block, and the bit area base in ram
  // ****************************************************
  localparam logic [7:0] SP_ADDR  = 8'h81;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [7:0] AUX_ADDR = 8'hF0;
  localparam logic [7:0] BITAREA_BASE = 8'h20;

  // ****************************************************
  // opcodes
  // ****************************************************
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_RET      = 8'h22;
  localparam logic [7:0] OP_RL       = 8'h23;
  localparam logic [7:0] OP_INTERRUPT_RETURN_OP     = 8'h32;
  localparam logic [7:0] OP_RLC      = 8'h33;
  localparam logic [7:0] OP_OR_D_A   = 8'h42;
  localparam logic [7:0] OP_OR_D_IMM = 8'h43;
  localparam logic [7:0] OP_OR_A_IMM = 8'h44;
  localparam logic [7:0] OP_OR_A_DIR = 8'h45;
  localparam logic [6:0] OP_OR_A_IND = 7'h23;
  localparam logic [4:0] OP_OR_A_RN  = 5'h09;
  localparam logic [7:0] OP_OR_C_BIT = 8'h72;
  localparam logic [7:0] OP_OR_C_NBT = 8'hA0;
  localparam logic [7:0] OP_MUL      = 8'hA4;
  localparam logic [7:0] OP_PUSH     = 8'hC0;
  localparam logic [7:0] OP_POP      = 8'hD0;

  // ****************************************************
  // sequencer states
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_PTR, ST_RD, ST_RD_LO, ST_FINISH
  } cmx_phase_t;

  // ****************************************************
  // decode helpers
  // ****************************************************
  function automatic logic [3:0] mcycles_of(input logic [7:0] op);
    if (op == OP_MUL)
      return 4'h4;
    else if (op == OP_OR_D_IMM || op == OP_OR_C_BIT ||
             op == OP_OR_C_NBT || op == OP_PUSH || op == OP_POP ||
             op == OP_RET || op == OP_INTERRUPT_RETURN_OP)
      return 4'h2;
    else
      return 4'h1;
  endfunction

  function automatic logic [1:0] bytes_of(input logic [7:0] op);
    if (op == OP_OR_D_IMM)
      return 2'h3;
    else if (op == OP_OR_D_A || op == OP_OR_A_IMM ||
             op == OP_OR_A_DIR || op == OP_OR_C_BIT ||
             op == OP_OR_C_NBT || op == OP_PUSH || op == OP_POP)
      return 2'h2;
    else
      return 2'h1;
  endfunction

  function automatic logic is_internal(input logic [7:0] dir);
    return dir == SP_ADDR || dir == ACC_ADDR || dir == AUX_ADDR;
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
    if (!baddr[7])
      return BITAREA_BASE + {4'h0, baddr[6:3]};
    else
      return {baddr[7:3], 3'h0};
  endfunction

endpackage
`default_nettype wire

// *** testbench/cmx_ram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// internal data ram, stack and port latches
// ****************************************
module cmx_ram_model (
  // clock
  input  wire logic       ref_clk,
  // access
  input  wire logic [7:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic       mem_we,
  input  wire logic       mem_re,
  input  wire logic       mem_latch_rd,
  output var  logic [7:0] mem_rdata
);
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  end
  always @(posedge ref_clk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
  // pins read inverted so a latch/pin mix-up shows; idle bus not held
  always_comb begin
    if (mem_re && !(mem_addr[7] && !mem_latch_rd)) mem_rdata = mem[mem_addr];
    else mem_rdata = ~mem[mem_addr];
  end
endmodule
`default_nettype wire

// *** testbench/cmx_exec_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port assertions
// ****************************************
module cmx_exec_checker
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // instruction
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic        busy,
  input  wire logic        done,
  // state
  input  wire logic [15:0] program_counter,
  input  wire logic [7:0]  accumulator,
  input  wire logic [7:0]  aux_reg,
  input  wire logic [7:0]  stack_pointer,
  input  wire logic        carry_flag,
  input  wire logic        overflow_flag,
  input  wire logic        parity_flag,
  input  wire logic        int_level_release,
  input  wire logic        int_hold,
  input  wire logic [7:0]  mem_addr,
  input  wire logic        mem_we
);
  logic take;
  assign take = instr_valid && !busy;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_mul_product: assert property (take && opcode == OP_MUL |=>
    {aux_reg, accumulator} == $past(accumulator) * $past(aux_reg))
    else $error("multiply product wrong");
  a_mul_flags: assert property (take && opcode == OP_MUL |=>
    !carry_flag && overflow_flag == (aux_reg != 8'h00))
    else $error("multiply flags wrong");
  a_mul_time: assert property (take && opcode == OP_MUL |=>
    !done [*8] ##1 done) else $error("multiply length wrong");
  a_nop_pc: assert property (take && opcode == OP_NOP |-> ##3
    done && program_counter == $past(program_counter, 3) + 16'h1)
    else $error("no-operation wrong");
  a_rl_ring: assert property (take && opcode == OP_RL |=>
    accumulator == {$past(accumulator[6:0]), $past(accumulator[7])}
    && $stable(carry_flag)) else $error("rotate wrong");
  a_rlc_ring: assert property (take && opcode == OP_RLC |=>
    {carry_flag, accumulator} == {$past(accumulator), $past(carry_flag)})
    else $error("rotate through carry wrong");
  a_parity_track: assert property (parity_flag == ^accumulator)
    else $error("parity wrong");
  a_push_write: assert property (take && opcode == OP_PUSH |=>
    stack_pointer == $past(stack_pointer) + 8'h1 ##[0:1]
    (mem_we && mem_addr == stack_pointer)) else $error("push wrong");
  a_ret_sp: assert property (take && (opcode == OP_RET ||
    opcode == OP_INTERRUPT_RETURN_OP) |-> ##5 done &&
    stack_pointer == $past(stack_pointer, 5) - 8'h2)
    else $error("return pointer wrong");
  a_release_hold: assert property (int_level_release |->
    done && int_hold) else $error("release without hold");
endmodule
bind cmx_exec cmx_exec_checker cmx_exec_checker_i (.ref_clk(ref_clk),
  .arst_n(arst_n), .instr_valid(instr_valid), .opcode(opcode),
  .busy(busy), .done(done), .program_counter(program_counter),
  .accumulator(accumulator), .aux_reg(aux_reg),
  .stack_pointer(stack_pointer), .carry_flag(carry_flag),
  .overflow_flag(overflow_flag), .parity_flag(parity_flag),
  .int_level_release(int_level_release), .int_hold(int_hold),
  .mem_addr(mem_addr), .mem_we(mem_we));
`default_nettype wire

// *** testbench/cmx_exec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmx_exec_tb
  import cmx_pkg::*;
;
  // ****************************************
  // design and ram
  // ****************************************
  logic ref_clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0;
  logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
  logic [1:0] bank_sel = 2'h0;
  logic busy, done, cy, ov, par, rel, hold, we, re, lrd;
  logic [15:0] pc, pc_exp;
  logic [7:0] acc, aux, sp, addr, wdata, rdata;
  int n_mismatch = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  cmx_exec cmx_exec_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .instr_valid(instr_valid), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .bank_sel(bank_sel), .busy(busy), .done(done),
    .program_counter(pc), .accumulator(acc), .aux_reg(aux),
    .stack_pointer(sp), .carry_flag(cy), .overflow_flag(ov),
    .parity_flag(par), .int_level_release(rel), .int_hold(hold),
    .mem_addr(addr), .mem_wdata(wdata), .mem_we(we), .mem_re(re),
    .mem_latch_rd(lrd), .mem_rdata(rdata));
  cmx_ram_model cmx_ram_model_i (.ref_clk(ref_clk), .mem_addr(addr),
    .mem_wdata(wdata), .mem_we(we), .mem_re(re), .mem_latch_rd(lrd),
    .mem_rdata(rdata));
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic end_of_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // nb bytes advance the pc, nc clocks from accept to done
  task automatic exec(input logic [7:0] op, o1, o2, input int nb, nc);
    int n;
    opcode = op;
    operand1 = o1;
    operand2 = o2;
    instr_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    instr_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    pc_exp = pc_exp + nb[15:0];
    cmp16(n[15:0], nc[15:0]);
    cmp16(pc, pc_exp);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    pc_exp = PC_RST;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    cmp8(acc, ACC_RST);
    cmp8(sp, SP_RST);
    cmp16(pc, PC_RST);
    $display("test reset over");
    exec(OP_OR_A_IMM, 8'h50, 8'h00, 2, 2);
    cmp8({7'h0, par}, 8'h00);
    exec(OP_PUSH, ACC_ADDR, 8'h00, 2, 4);
    cmp8(cmx_ram_model_i.mem[8'h08], 8'h50);
    exec(OP_OR_A_IMM, 8'hA0, 8'h00, 2, 2);
    exec(OP_POP, AUX_ADDR, 8'h00, 2, 4);
    cmp8(aux, 8'h50);
    cmp8(sp, 8'h07);
    exec(OP_MUL, 8'h00, 8'h00, 1, 8);
    cmp8(acc, 8'h00);
    cmp8(aux, 8'h4B);
    cmp8({6'h0, ov, cy}, 8'h02);
    exec(OP_MUL, 8'h00, 8'h00, 1, 8);
    cmp8({6'h0, ov, cy}, 8'h00);
    $display("test multiply over");
    exec(OP_OR_A_IMM, 8'hC5, 8'h00, 2, 2);
    exec(OP_RL, 8'h00, 8'h00, 1, 2);
    cmp8(acc, 8'h8B);
    exec(OP_RLC, 8'h00, 8'h00, 1, 2);
    cmp8({cy, acc[7:1]}, {1'b1, 7'h0B});
    exec(OP_RLC, 8'h00, 8'h00, 1, 2);
    exec(OP_NOP, 8'h00, 8'h00, 1, 2);
    cmp8(acc, 8'h2D);
    cmp8({7'h0, cy}, 8'h00);
    $display("test rotate over");
    exec(OP_OR_D_A, 8'h90, 8'h00, 2, 2);
    cmp8(cmx_ram_model_i.mem[8'h90], 8'hBD);
    exec(OP_OR_D_IMM, 8'h90, 8'h03, 3, 4);
    cmp8(cmx_ram_model_i.mem[8'h90], 8'hBF);
    cmp8(acc, 8'h2D);
    exec(OP_OR_A_DIR, 8'h30, 8'h00, 2, 2);
    cmp8({par, acc[6:0]}, {1'b1, 7'h3D});
    bank_sel = 2'h1;
    exec(OP_OR_D_IMM, 8'h09, 8'h70, 3, 4);
    exec({OP_OR_A_IND, 1'b1}, 8'h00, 8'h00, 1, 3);
    cmp8(acc, 8'h7D);
    $display("test byte or over");
    exec(OP_MUL, 8'h00, 8'h00, 1, 8);
    exec(OP_OR_C_BIT, 8'h07, 8'h00, 2, 4);
    cmp8({7'h0, cy}, 8'h00);
    exec(OP_OR_C_BIT, 8'h05, 8'h00, 2, 4);
    cmp8({7'h0, cy}, 8'h01);
    exec(OP_MUL, 8'h00, 8'h00, 1, 8);
    exec(OP_OR_C_NBT, 8'h05, 8'h00, 2, 4);
    cmp8({7'h0, cy}, 8'h00);
    exec(OP_OR_C_NBT, 8'h07, 8'h00, 2, 4);
    cmp8({7'h0, cy}, 8'h01);
    cmp8(cmx_ram_model_i.mem[8'h20], 8'h20);
    $display("test bit or over");
    exec(OP_PUSH, 8'h30, 8'h00, 2, 4);
    exec(OP_POP, SP_ADDR, 8'h00, 2, 4);
    cmp8(sp, 8'h30);
    for (int k = 0; k < 2; k++) begin
      exec(OP_PUSH, 8'h23, 8'h00, 2, 4);
      exec(OP_PUSH, 8'h01, 8'h00, 2, 4);
      pc_exp = 16'h0123;
      exec(k == 0 ? OP_RET : OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00, 0, 4);
      cmp8(sp, 8'h30);
      cmp8({6'h0, rel, hold}, k == 0 ? 8'h00 : 8'h03);
    end
    exec(OP_NOP, 8'h00, 8'h00, 1, 2);
    cmp8({7'h0, hold}, 8'h00);
    $display("test stack over");
    end_of_test();
  end
endmodule
`default_nettype wire
